// file: rtl/async_serial_transceiver.sv
// full-duplex asynchronous serial transceiver with an AXI4-Lite register slave
// What this block does
// - writing transmit enable 0 resets the transmitter and holds it off
// - writing transmit enable 1 lets the transmitter accept triggers
// - in 7-bit mode the top data bit is ignored, seven bits sent
// - transmit trigger starts shift clock; low start bit on a clock edge
// - data bits then leave one per shift clock edge
// - after data and parity a high stop bit, line stays high
// - a finished frame sets the transmit done flag
// - receive enable 0 stops reception and clears the three error flags
// - receive enable 1 makes the receiver watch for a start bit
// - a low start bit starts the shift clock; bits sampled mid-bit afterwards
// - a low stop bit sets framing error and receive error flags
// - frame end moves data to the buffer and sets done unless overrun
// - with parity on, a mismatch sets parity error and receive error
// - parity counts data ones plus parity bit: even or odd total
// - errored words still reach the buffer and reception continues
// - a frame ending before acknowledge sets overrun and receive error
// - acknowledge in the same cycle as a transfer counts as overrun
// - error flags clear on a write of 1, writing 0 leaves them
// - one start bit; stop length select 1 gives two stops, 0 one
// - parity appended and checked automatically; polarity 1 odd, 0 even
// - mode low 0 high 1 is 7-bit, low 1 high 1 is 8-bit
// - bit order select sends and receives from bit 0 or the top data bit (7, or 6 in 7-bit mode)
`include "uart_cfg.svh"
`default_nettype none

module async_serial_transceiver
	import uart_pkg::*;
(
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic ce,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic serial_in_pin,
	output logic serial_out_pin
);

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	logic awHeld_r, wHeld_r;
	logic [7:0] awAddr_r;
	logic [31:0] wData_r;
	logic [3:0] wStrb_r;
	logic [1:0] bresp_r, rresp_r;
	logic bvalid_r, rvalid_r;
	logic [31:0] rdata_r;
	logic txEnR, rxEnR;
	frame_cfg_t cfg_r;
	logic [7:0] txData_r, rxBuf_r;
	logic [15:0] divisor_r;
	flags_t flags_r, flagSet, flagClr, flags_nxt;
	tx_state_t txState;
	rx_state_t rxState;
	logic [7:0] txShift_r, rxShift_r;
	logic [3:0] txCnt_r, rxCnt_r;
	logic txStop2_r, rxParBit_r, bufFull_r, serialOut_r;
	logic txTick, rxTick;

	// ----------------------------------------------------------------
	// bus decode
	// ----------------------------------------------------------------
	wire wrFire = ce && awHeld_r && wHeld_r && !bvalid_r;
	wire [7:0] wrByte = wData_r[7:0];
	wire wrLow = wrFire && wStrb_r[0];
	wire wrCtrl = wrLow && (awAddr_r == `REG_CTRL);
	wire wrFlag = wrLow && (awAddr_r == `REG_FLAG);
	wire wrMode = wrLow && (awAddr_r == `REG_MODE);
	wire wrFrame = wrLow && (awAddr_r == `REG_FRAME);
	wire wrData = wrLow && (awAddr_r == `REG_DATA);
	wire wrDiv = wrFire && (awAddr_r == `REG_DIV);
	wire wrHit = (awAddr_r == `REG_CTRL) || (awAddr_r == `REG_FLAG) ||
		(awAddr_r == `REG_MODE) || (awAddr_r == `REG_FRAME) ||
		(awAddr_r == `REG_DATA) || (awAddr_r == `REG_DIV);
	wire txTrigWr = wrCtrl && wrByte[`CTRL_TX_TRIGGER];
	wire rxAckWr = wrCtrl && wrByte[`CTRL_RX_ACK];
	wire rdFire = s_axi_arvalid && s_axi_arready;

	// ----------------------------------------------------------------
	// frame format
	// ----------------------------------------------------------------
	// synchronous modes are not built: only mode high = 1 runs a frame
	wire asyncMode = cfg_r.modeHigh;
	wire [3:0] nBits = cfg_r.modeLow ? 4'h8 : 4'h7;
	wire [2:0] lastIdx = cfg_r.modeLow ? 3'h7 : 3'h6;
	wire [7:0] txMasked = {cfg_r.modeLow & txData_r[7], txData_r[6:0]};
	wire [2:0] txIdx = cfg_r.msbFirst ? lastIdx - txCnt_r[2:0] : txCnt_r[2:0];
	wire [2:0] rxIdx = cfg_r.msbFirst ? lastIdx - rxCnt_r[2:0] : rxCnt_r[2:0];
	wire txParity = (^txShift_r) ^ cfg_r.parityOdd;
	wire txRun = (txState != TX_IDLE);
	wire rxRun = (rxState != RX_IDLE);
	wire txGo = txTrigWr && txEnR && !txRun && asyncMode;
	wire txFinish = (txState == TX_STOP) && txTick && !(cfg_r.stopTwo && !txStop2_r);
	// a frame cut by disable must not set error flags that disable clears
	wire frameEnd = rxEnR && (rxState == RX_STOP) && rxTick;
	wire ovrNow = bufFull_r || rxAckWr;
	wire parBad = cfg_r.parityOn && (((^rxShift_r) ^ rxParBit_r) != cfg_r.parityOdd);
	wire frmBad = !serial_in_pin;

	// ----------------------------------------------------------------
	// bus handshakes and read mux
	// ----------------------------------------------------------------
	assign s_axi_awready = ce && !awHeld_r;
	assign s_axi_wready = ce && !wHeld_r;
	assign s_axi_arready = ce && !rvalid_r;
	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rdata = rdata_r;
	assign s_axi_rresp = rresp_r;
	assign serial_out_pin = serialOut_r;

	wire [7:0] ctrlRd = {4'h0, rxRun, rxEnR, txRun, txEnR};
	wire [7:0] flagRd = {1'b0, flags_r.framingErr, flags_r.parityErr, flags_r.overrunErr,
		1'b0, flags_r.rxErr, flags_r.rxDone, flags_r.txDone};
	wire [7:0] modeRd = {1'b0, cfg_r.parityOn, cfg_r.parityOdd, 2'b00,
		cfg_r.modeHigh, cfg_r.modeLow, 1'b0};
	wire [7:0] frameRd = {6'h00, cfg_r.stopTwo, cfg_r.msbFirst};
	wire rdHit = (s_axi_araddr == `REG_CTRL) || (s_axi_araddr == `REG_FLAG) ||
		(s_axi_araddr == `REG_MODE) || (s_axi_araddr == `REG_FRAME) ||
		(s_axi_araddr == `REG_DATA) || (s_axi_araddr == `REG_DIV);
	wire [31:0] rdMux =
		(s_axi_araddr == `REG_CTRL) ? {24'h000000, ctrlRd} :
		(s_axi_araddr == `REG_FLAG) ? {24'h000000, flagRd} :
		(s_axi_araddr == `REG_MODE) ? {24'h000000, modeRd} :
		(s_axi_araddr == `REG_FRAME) ? {24'h000000, frameRd} :
		(s_axi_araddr == `REG_DATA) ? {24'h000000, rxBuf_r} :
		(s_axi_araddr == `REG_DIV) ? {16'h0000, divisor_r} : 32'h00000000;

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			awHeld_r <= 1'b0;
			wHeld_r <= 1'b0;
			awAddr_r <= 8'h00;
			wData_r <= 32'h00000000;
			wStrb_r <= 4'h0;
			bvalid_r <= 1'b0;
			bresp_r <= `RESP_OKAY;
		end else if (ce) begin
			if (s_axi_awvalid && s_axi_awready) begin
				awHeld_r <= 1'b1;
				awAddr_r <= s_axi_awaddr;
			end else if (wrFire) begin
				awHeld_r <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wHeld_r <= 1'b1;
				wData_r <= s_axi_wdata;
				wStrb_r <= s_axi_wstrb;
			end else if (wrFire) begin
				wHeld_r <= 1'b0;
			end
			if (wrFire) begin
				bvalid_r <= 1'b1;
				bresp_r <= wrHit ? `RESP_OKAY : `RESP_SLVERR;
			end else if (s_axi_bready) begin
				bvalid_r <= 1'b0;
			end
		end
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			rvalid_r <= 1'b0;
			rdata_r <= 32'h00000000;
			rresp_r <= `RESP_OKAY;
		end else if (ce) begin
			if (rdFire) begin
				rvalid_r <= 1'b1;
				rdata_r <= rdMux;
				rresp_r <= rdHit ? `RESP_OKAY : `RESP_SLVERR;
			end else if (s_axi_rready) begin
				rvalid_r <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// software registers
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			txEnR <= 1'b0;
			rxEnR <= 1'b0;
			cfg_r <= '0;
			txData_r <= 8'h00;
			divisor_r <= 16'(`DIV_RESET);
		end else if (ce) begin
			if (wrCtrl) begin
				txEnR <= wrByte[`CTRL_TX_ENABLE];
				rxEnR <= wrByte[`CTRL_RX_ENABLE];
			end
			if (wrMode) begin
				cfg_r.modeLow <= wrByte[`MODE_LOW];
				cfg_r.modeHigh <= wrByte[`MODE_HIGH];
				cfg_r.parityOdd <= wrByte[`MODE_PARITY_ODD];
				cfg_r.parityOn <= wrByte[`MODE_PARITY_ON];
			end
			if (wrFrame) begin
				cfg_r.msbFirst <= wrByte[`FRAME_BIT_ORDER];
				cfg_r.stopTwo <= wrByte[`FRAME_STOP_LEN];
			end
			if (wrData) begin
				txData_r <= wrByte;
			end
			if (wrDiv && wStrb_r[0]) begin
				divisor_r[7:0] <= wData_r[7:0];
			end
			if (wrDiv && wStrb_r[1]) begin
				divisor_r[15:8] <= wData_r[15:8];
			end
		end
	end

	// ----------------------------------------------------------------
	// event flags: a set in the clearing cycle wins
	// ----------------------------------------------------------------
	assign flagSet.txDone = txFinish;
	assign flagSet.rxDone = frameEnd && !ovrNow;
	assign flagSet.overrunErr = frameEnd && ovrNow;
	assign flagSet.parityErr = frameEnd && parBad;
	assign flagSet.framingErr = frameEnd && frmBad;
	assign flagSet.rxErr = frameEnd && (ovrNow || parBad || frmBad);
	assign flagClr.txDone = wrFlag && wrByte[`FLAG_TX_DONE];
	assign flagClr.rxDone = wrFlag && wrByte[`FLAG_RX_DONE];
	assign flagClr.rxErr = wrFlag && wrByte[`FLAG_RX_ERROR];
	// disabled receiver also wipes the three error flags
	assign flagClr.overrunErr = (wrFlag && wrByte[`FLAG_OVERRUN]) || !rxEnR;
	assign flagClr.parityErr = (wrFlag && wrByte[`FLAG_PARITY]) || !rxEnR;
	assign flagClr.framingErr = (wrFlag && wrByte[`FLAG_FRAMING]) || !rxEnR;
	assign flags_nxt = flagSet | (flags_r & ~flagClr);

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			flags_r <= '0;
		end else if (ce) begin
			flags_r <= flags_nxt;
		end
	end

	// ----------------------------------------------------------------
	// shift clocks
	// ----------------------------------------------------------------
	bit_rate_timer txTimer (
		.core_clk(core_clk),
		.arst_n(arst_n),
		.ce(ce),
		.run(txRun),
		.halfFirst(1'b0),
		.divisor(divisor_r),
		.tick(txTick)
	);

	bit_rate_timer rxTimer (
		.core_clk(core_clk),
		.arst_n(arst_n),
		.ce(ce),
		.run(rxRun),
		.halfFirst(1'b1),
		.divisor(divisor_r),
		.tick(rxTick)
	);

	// ----------------------------------------------------------------
	// transmitter
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			txState <= TX_IDLE;
			serialOut_r <= 1'b1;
			txShift_r <= 8'h00;
			txCnt_r <= 4'h0;
			txStop2_r <= 1'b0;
		end else if (ce) begin
			if (!txEnR) begin
				txState <= TX_IDLE;
				serialOut_r <= 1'b1;
			end else begin
				case (txState)
					TX_IDLE: if (txGo) begin
						txState <= TX_WAIT;
						txShift_r <= txMasked;
						txCnt_r <= 4'h0;
						txStop2_r <= 1'b0;
					end
					TX_WAIT: if (txTick) begin
						serialOut_r <= 1'b0;
						txState <= TX_START;
					end
					TX_START: if (txTick) begin
						serialOut_r <= txShift_r[txIdx];
						txCnt_r <= 4'h1;
						txState <= TX_DATA;
					end
					TX_DATA: if (txTick) begin
						if (txCnt_r == nBits) begin
							serialOut_r <= cfg_r.parityOn ? txParity : 1'b1;
							txState <= cfg_r.parityOn ? TX_PAR : TX_STOP;
						end else begin
							serialOut_r <= txShift_r[txIdx];
							txCnt_r <= txCnt_r + 4'h1;
						end
					end
					TX_PAR: if (txTick) begin
						serialOut_r <= 1'b1;
						txState <= TX_STOP;
					end
					TX_STOP: if (txTick) begin
						txStop2_r <= 1'b1;
						if (txFinish) begin
							txState <= TX_IDLE;
						end
					end
					default: txState <= TX_IDLE;
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// receiver
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			rxState <= RX_IDLE;
			rxShift_r <= 8'h00;
			rxCnt_r <= 4'h0;
			rxParBit_r <= 1'b0;
		end else if (ce) begin
			if (!rxEnR) begin
				rxState <= RX_IDLE;
			end else begin
				case (rxState)
					RX_IDLE: if (asyncMode && !serial_in_pin) begin
						rxState <= RX_START;
						rxShift_r <= 8'h00;
						rxCnt_r <= 4'h0;
					end
					// a start bit gone high by mid-bit is a glitch, not a frame
					RX_START: if (rxTick) begin
						rxState <= serial_in_pin ? RX_IDLE : RX_DATA;
					end
					RX_DATA: if (rxTick) begin
						rxShift_r[rxIdx] <= serial_in_pin;
						rxCnt_r <= rxCnt_r + 4'h1;
						if (rxCnt_r == nBits - 4'h1) begin
							rxState <= cfg_r.parityOn ? RX_PAR : RX_STOP;
						end
					end
					RX_PAR: if (rxTick) begin
						rxParBit_r <= serial_in_pin;
						rxState <= RX_STOP;
					end
					RX_STOP: if (rxTick) begin
						rxState <= RX_IDLE;
					end
					default: rxState <= RX_IDLE;
				endcase
			end
		end
	end

	// the buffer is written even on error so software sees what arrived
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			rxBuf_r <= 8'h00;
			bufFull_r <= 1'b0;
		end else if (ce) begin
			if (frameEnd) begin
				rxBuf_r <= rxShift_r;
				bufFull_r <= 1'b1;
			end else if (rxAckWr || !rxEnR) begin
				bufFull_r <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	a_tx_disable: assert property (@(posedge core_clk) disable iff (!arst_n)
		(ce && !txEnR) |=> (txState == TX_IDLE) && serial_out_pin)
		else $error("transmitter not held idle while disabled");
	a_tx_start_low: assert property (@(posedge core_clk) disable iff (!arst_n)
		(txEnR && txState == TX_WAIT && txTick) |=> !serial_out_pin && txState == TX_START)
		else $error("start bit not driven low on shift tick");
	a_tx_idle_high: assert property (@(posedge core_clk) disable iff (!arst_n)
		(txState == TX_IDLE || txState == TX_STOP || txState == TX_WAIT) |-> serial_out_pin)
		else $error("line not high outside data bits");
	a_tx_done_flag: assert property (@(posedge core_clk) disable iff (!arst_n)
		(txEnR && txFinish) |=> flags_r.txDone && !txRun)
		else $error("transmit done not flagged at frame end");
	a_rx_dis_clear: assert property (@(posedge core_clk) disable iff (!arst_n)
		(ce && !rxEnR) |=> !flags_r.parityErr && !flags_r.overrunErr && !flags_r.framingErr)
		else $error("error flags survive receive disable");
	a_rx_overrun: assert property (@(posedge core_clk) disable iff (!arst_n)
		(frameEnd && (bufFull_r || rxAckWr)) |=>
		flags_r.overrunErr && flags_r.rxErr && (!flags_r.rxDone || $past(flags_r.rxDone)))
		else $error("overrun not flagged or done wrongly set");
	a_rx_done: assert property (@(posedge core_clk) disable iff (!arst_n)
		(frameEnd && !bufFull_r && !rxAckWr) |=> flags_r.rxDone && rxBuf_r == $past(rxShift_r))
		else $error("clean frame not delivered");
	a_rx_framing: assert property (@(posedge core_clk) disable iff (!arst_n)
		(frameEnd && !serial_in_pin) |=> flags_r.framingErr && flags_r.rxErr)
		else $error("low stop bit not flagged");
	a_err_w1c: assert property (@(posedge core_clk) disable iff (!arst_n)
		(wrFlag && wrByte[`FLAG_PARITY] && !frameEnd) |=> !flags_r.parityErr)
		else $error("parity error flag not cleared by write of one");

endmodule

`default_nettype wire

// file: rtl/uart_cfg.svh
// register offsets, field positions, reset values and timing counts of the serial block
`ifndef UART_CFG_SVH
`define UART_CFG_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define REG_CTRL 8'h00
`define REG_FLAG 8'h04
`define REG_MODE 8'h08
`define REG_FRAME 8'h0C
`define REG_DATA 8'h10
`define REG_DIV 8'h14

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define CTRL_TX_ENABLE 0
`define CTRL_TX_TRIGGER 1
`define CTRL_RX_ENABLE 2
`define CTRL_RX_ACK 3
`define FLAG_TX_DONE 0
`define FLAG_RX_DONE 1
`define FLAG_RX_ERROR 2
`define FLAG_OVERRUN 4
`define FLAG_PARITY 5
`define FLAG_FRAMING 6
`define MODE_LOW 1
`define MODE_HIGH 2
`define MODE_PARITY_ODD 5
`define MODE_PARITY_ON 6
`define FRAME_BIT_ORDER 0
`define FRAME_STOP_LEN 1

// ----------------------------------------------------------------
// timing and reset values
// ----------------------------------------------------------------
`define CLK_HZ 25000000
`define BAUD_DEFAULT 115200
`define DIV_RESET (`CLK_HZ / `BAUD_DEFAULT)
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// file: rtl/uart_pkg.sv
// types shared by the serial transceiver files
`default_nettype none

package uart_pkg;

	typedef enum logic [2:0] {TX_IDLE, TX_WAIT, TX_START, TX_DATA, TX_PAR, TX_STOP} tx_state_t;
	typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} rx_state_t;

	typedef struct packed {
		logic parityOn;
		logic parityOdd;
		logic modeHigh;
		logic modeLow;
		logic stopTwo;
		logic msbFirst;
	} frame_cfg_t;

	typedef struct packed {
		logic framingErr;
		logic parityErr;
		logic overrunErr;
		logic rxErr;
		logic rxDone;
		logic txDone;
	} flags_t;

endpackage

`default_nettype wire

// file: rtl/bit_rate_timer.sv
// shift clock generator: one tick per bit period while running
`default_nettype none

module bit_rate_timer
	import uart_pkg::*;
(
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic ce,
	input wire logic run,
	input wire logic halfFirst,
	input wire logic [15:0] divisor,
	output logic tick
);

	logic [15:0] count_r;
	logic [15:0] reload;
	logic [15:0] firstLoad;

	// a zero divisor would stall the frame, so it acts as one
	assign reload = (divisor == 16'h0000) ? 16'h0001 : divisor;
	// receiver starts half a bit late so it samples mid-bit
	assign firstLoad = !halfFirst ? reload :
		(reload[15:1] == 15'h0000) ? 16'h0001 : {1'b0, reload[15:1]};
	assign tick = ce && run && (count_r <= 16'h0001);

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			count_r <= 16'h0001;
		end else if (ce) begin
			if (!run) begin
				count_r <= firstLoad;
			end else if (count_r <= 16'h0001) begin
				count_r <= reload;
			end else begin
				count_r <= count_r - 16'h0001;
			end
		end
	end

endmodule

`default_nettype wire

// file: sim/remote_serial_peer.sv
// remote serial device model on the transmit and receive lines
`default_nettype none

module remote_serial_peer #(
	parameter int DIV = 4
) (
	input wire logic core_clk,
	input wire logic lineIn,
	output var logic lineOut
);
	timeunit 1ns;
	timeprecision 1ns;

	// ----------------------------------------------------------------
	// line drive and capture
	// ----------------------------------------------------------------
	// mark level while idle, as the remote end keeps it between frames
	initial lineOut = 1'b1;

	task automatic send(input logic [11:0] f);
		for (int k = 0; k < 12; k++) begin
			@(posedge core_clk);
			lineOut <= f[k];
			repeat (DIV - 1) @(posedge core_clk);
		end
	endtask

	// mid-bit samples; the trailing slots show whether the line went back high
	task automatic grab(output logic [11:0] f);
		@(posedge core_clk iff lineIn === 1'b0);
		repeat (DIV / 2) @(posedge core_clk);
		for (int k = 0; k < 12; k++) begin
			f[k] = lineIn;
			repeat (DIV) @(posedge core_clk);
		end
	endtask
endmodule

`default_nettype wire

// file: sim/tb_async_serial_transceiver.sv
// self-checking bench for the serial transceiver through its register bus
`include "uart_cfg.svh"
`default_nettype none

module tb_async_serial_transceiver import uart_pkg::*; ();
	timeunit 1ns;
	timeprecision 1ns;
	localparam int DIV = 4;
	logic core_clk = 1'b0;
	logic arst_n = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00;
	logic [7:0] s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [31:0] s_axi_rdata;
	logic s_axi_awvalid = 1'b0;
	logic s_axi_wvalid = 1'b0;
	logic s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0;
	logic s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic serial_in_pin, serial_out_pin;
	int n_mismatch = 0;
	int n_checks = 0;

	async_serial_transceiver u_dut (.core_clk, .arst_n, .ce(1'b1), .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .serial_in_pin, .serial_out_pin);

	remote_serial_peer #(.DIV(DIV)) u_peer (.core_clk, .lineIn(serial_out_pin),
		.lineOut(serial_in_pin));

	initial begin
		forever #20 core_clk = ~core_clk;
	end

	// ----------------------------------------------------------------
	// bus and compare tasks
	// ----------------------------------------------------------------
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask

	// ready and valid are looked at mid-cycle, acted on at the next rising edge
	task automatic axWrite(input logic [7:0] a, input logic [31:0] d);
		logic aw, w, b;
		logic [1:0] br;
		int t;
		@(posedge core_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		b = 1'b0;
		for (t = 0; !b && t < 200; t++) begin
			@(negedge core_clk);
			aw = s_axi_awvalid & s_axi_awready;
			w = s_axi_wvalid & s_axi_wready;
			b = s_axi_bvalid;
			br = s_axi_bresp;
			@(posedge core_clk);
			if (aw) s_axi_awvalid <= 1'b0;
			if (w) s_axi_wvalid <= 1'b0;
		end
		s_axi_bready <= 1'b0;
		chk("write answer", 32'h1, {31'h0, b});
		chk("write response", (a > `REG_DIV) ? {30'h0, `RESP_SLVERR} : {30'h0, `RESP_OKAY},
			{30'h0, br});
	endtask

	task automatic axRead(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		logic ar, rv;
		int t;
		@(posedge core_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		rv = 1'b0;
		for (t = 0; !rv && t < 200; t++) begin
			@(negedge core_clk);
			ar = s_axi_arvalid & s_axi_arready;
			rv = s_axi_rvalid;
			d = s_axi_rdata;
			r = s_axi_rresp;
			@(posedge core_clk);
			if (ar) s_axi_arvalid <= 1'b0;
		end
		s_axi_rready <= 1'b0;
		chk("read answer", 32'h1, {31'h0, rv});
	endtask

	task automatic rdChk(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] d;
		logic [1:0] r;
		axRead(a, d, r);
		chk($sformatf("register %h", a), e, d);
	endtask

	// ----------------------------------------------------------------
	// frame helpers
	// ----------------------------------------------------------------
	// bit k is the k-th bit on the line; unused slots stay at the idle level
	function automatic logic [11:0] mkFrame(input frame_cfg_t c, input logic [7:0] d);
		logic [11:0] f;
		int n;
		n = c.modeLow ? 8 : 7;
		f = 12'hFFF;
		f[0] = 1'b0;
		for (int k = 0; k < n; k++) f[1 + k] = c.msbFirst ? d[n - 1 - k] : d[k];
		if (c.parityOn) f[1 + n] = (^(d & (c.modeLow ? 8'hFF : 8'h7F))) ^ c.parityOdd;
		return f;
	endfunction

	task automatic cfgSet(input frame_cfg_t c);
		axWrite(`REG_MODE, {25'h0, c.parityOn, c.parityOdd, 2'h0, c.modeHigh, c.modeLow, 1'b0});
		axWrite(`REG_FRAME, {30'h0, c.stopTwo, c.msbFirst});
	endtask

	task automatic txFrame(input frame_cfg_t c, input logic [7:0] d);
		logic [11:0] f;
		logic [31:0] v;
		logic [1:0] r;
		cfgSet(c);
		axWrite(`REG_DATA, {24'h0, d});
		fork
			u_peer.grab(f);
			begin
				axWrite(`REG_CTRL, 32'h3);
				rdChk(`REG_CTRL, 32'h3);
			end
		join
		chk("tx frame", {20'h0, mkFrame(c, d)}, {20'h0, f});
		v = 32'h0;
		for (int k = 0; k < 20 && v[0] !== 1'b1; k++) axRead(`REG_FLAG, v, r);
		chk("tx done", 32'h1, v);
		rdChk(`REG_CTRL, 32'h1);
		axWrite(`REG_FLAG, 32'h1);
	endtask

	task automatic rxFrame(input logic [7:0] d, input logic [11:0] flip, input logic [31:0] fl);
		u_peer.send(mkFrame(6'h2C, d) ^ flip);
		rdChk(`REG_FLAG, fl);
		rdChk(`REG_DATA, {24'h0, d});
	endtask

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// ----------------------------------------------------------------
	// test sequence
	// ----------------------------------------------------------------
	initial begin
		logic [31:0] v;
		logic [1:0] r;
		repeat (2) @(posedge core_clk);
		arst_n <= 1'b1;
		chk("idle line", 32'h1, {31'h0, serial_out_pin});
		rdChk(`REG_FLAG, 32'h0);
		rdChk(`REG_DIV, 32'hD9);
		axRead(8'h18, v, r);
		chk("unmapped response", {30'h0, `RESP_SLVERR}, {30'h0, r});
		axWrite(8'h18, 32'hFF);
		axWrite(`REG_DIV, 32'(DIV));
		axWrite(`REG_CTRL, 32'h1);
		// synchronous mode selected: a trigger must not start a frame
		cfgSet(6'h04);
		axWrite(`REG_CTRL, 32'h3);
		rdChk(`REG_CTRL, 32'h1);
		txFrame(6'h0C, 8'hA5);
		txFrame(6'h3B, 8'hC3);
		txFrame(6'h2E, 8'h81);
		axWrite(`REG_CTRL, 32'h3);
		repeat (3 * DIV) @(posedge core_clk);
		axWrite(`REG_CTRL, 32'h4);
		repeat (DIV) @(posedge core_clk);
		chk("line after abort", 32'h1, {31'h0, serial_out_pin});
		axWrite(`REG_CTRL, 32'h6);
		rdChk(`REG_CTRL, 32'h4);
		rdChk(`REG_FLAG, 32'h0);
		cfgSet(6'h2C);
		rxFrame(8'h3C, 12'h000, 32'h2);
		axWrite(`REG_FLAG, 32'h77);
		axWrite(`REG_CTRL, 32'hC);
		rxFrame(8'h5A, 12'h200, 32'h26);
		axWrite(`REG_FLAG, 32'h0);
		rdChk(`REG_FLAG, 32'h26);
		axWrite(`REG_FLAG, 32'h20);
		rdChk(`REG_FLAG, 32'h6);
		axWrite(`REG_FLAG, 32'h77);
		axWrite(`REG_CTRL, 32'hC);
		rxFrame(8'hC7, 12'h400, 32'h46);
		axWrite(`REG_FLAG, 32'h77);
		axWrite(`REG_CTRL, 32'hC);
		rxFrame(8'h11, 12'h000, 32'h2);
		axWrite(`REG_FLAG, 32'h2);
		rxFrame(8'hEE, 12'h000, 32'h14);
		axWrite(`REG_CTRL, 32'h0);
		rdChk(`REG_FLAG, 32'h4);
		wrap_up();
	end

	initial begin
		repeat (20000) @(posedge core_clk);
		$display("BAD watchdog expected finish seen timeout");
		n_mismatch++;
		wrap_up();
	end
endmodule

`default_nettype wire
